// >>> common/link_err_pkg.sv
`default_nettype none
package link_err_pkg;
  // error classes
  localparam logic [7:0]  CLASS_HW_FAULT      = 8'h84;
  localparam logic [7:0]  CLASS_LINK_SEQ      = 8'h86;
  localparam logic [7:0]  CLASS_PARAM_BAD     = 8'h89;
  // first word of a normal-sequence station error: 10, station, 4
  localparam logic [7:0]  WORD0_SEQ_HIGH      = 8'h10;
  localparam logic [3:0]  WORD0_NORMAL_SEQ    = 4'h4;
  localparam logic [15:0] WORD0_NO_MASTER     = 16'h1007;
  // detail words
  localparam logic [15:0] DETAIL_HPAR_ERR     = 16'h0000;
  localparam logic [15:0] DETAIL_HPAR_MISSING = 16'h00E6;
  localparam logic [15:0] DETAIL_VPAR_ERR     = 16'h00E8;
  localparam logic [15:0] DETAIL_NO_MASTER    = 16'h00E4;
  localparam logic [15:0] WORD_NONE           = 16'h0000;
  // station 1 reports as address 62, one more per station
  localparam logic [7:0]  STATION_ADDR_FIRST  = 8'h62;
  localparam logic [3:0]  STATION_LAST        = 4'hF;
  // history depth and reset fill
  localparam int          HIST_DEPTH          = 8;
  localparam logic [3:0]  HIST_COUNT_RESET    = 4'h0;

  // one stored error record
  typedef struct packed {
    logic [7:0]  class_code;          // 84, 86 or 89
    logic [3:0]  link_code;           // odd hex digit for link 1..8
    logic [15:0] error_record_word0;  // first word
    logic [15:0] error_detail_word;   // detail word
    logic [15:0] error_station_word;  // station address in low byte
  } record_t;

  localparam record_t RECORD_EMPTY = '0;
endpackage
`default_nettype wire

// >>> common/err_rec_if.sv
`default_nettype none
interface err_rec_if;
  logic                    push;    // one-cycle: store rec
  link_err_pkg::record_t   rec;     // record to store
  logic [2:0]              rd_idx;  // 0 = newest
  link_err_pkg::record_t   rd_rec;  // registered read data
  logic [3:0]              count;   // entries held

  modport writer (output push, output rec, output rd_idx, input rd_rec, input count);
  modport store  (input push, input rec, input rd_idx, output rd_rec, output count);
endinterface
`default_nettype wire

// >>> core/err_history.sv
`default_nettype none
module err_history #(
  parameter int DEPTH = link_err_pkg::HIST_DEPTH
) (
  input  wire logic  i_core_clk,
  input  wire logic  i_sys_rst,
  err_rec_if.store   hist
);
  // the read index and count are sized for at most eight entries
  if (DEPTH < 2 || DEPTH > 8)
  begin : g_depth_check
    $error("err_history: DEPTH must be 2..8");
  end

  link_err_pkg::record_t entry [DEPTH];  // entry 0 is newest
  logic [3:0]            next_count;     // saturating fill level
  logic                  rd_in_range;    // index points at a held entry

  assign next_count  = (hist.count == 4'(DEPTH)) ? hist.count : 4'(hist.count + 4'h1);
  assign rd_in_range = {1'b0, hist.rd_idx} < hist.count;

  // shift stages: each push moves every entry one older
  for (genvar i = 0; i < DEPTH; i++)
  begin : g_stage
    always_ff @(posedge i_core_clk)
    begin
      if (i_sys_rst)
        entry[i] <= link_err_pkg::RECORD_EMPTY;
      else if (hist.push)
        entry[i] <= (i == 0) ? hist.rec : entry[(i == 0) ? 0 : i - 1];
    end
  end

  // fill level and registered read port
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      hist.count  <= link_err_pkg::HIST_COUNT_RESET;
      hist.rd_rec <= link_err_pkg::RECORD_EMPTY;
    end
    else
    begin
      if (hist.push)
        hist.count <= next_count;
      // unfilled slots read as zero
      hist.rd_rec <= rd_in_range ? entry[hist.rd_idx] : link_err_pkg::RECORD_EMPTY;
    end
  end

  // ninth error: oldest falls out, newer ones move down
  oldest_drop_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    hist.push && hist.count == 4'(DEPTH)
    |=> hist.count == 4'(DEPTH) && entry[DEPTH-1] == $past(entry[DEPTH-2]))
    else $error("full history did not drop its oldest entry");
endmodule
`default_nettype wire

// >>> core/link_error_code_logger.sv
// Operation
// - link 1..8 coded as odd hex digit
// - stations 1..15 reported as addresses 62..70
// - horizontal parity error logs class 86, 10*4
// - missing horizontal parity logs detail 00E6
// - slave without master data logs 1007/00E4
// - module or processor interface fault logs 84
// - inconsistent link parameter logs class 89
// - eight-deep shifting history of error records
// - separated station failing logs nothing
// - vertical parity error logs detail 00E8
`default_nettype none
module link_error_code_logger (
  input  wire logic         i_core_clk,         // system clock
  input  wire logic         i_sys_rst,          // synchronous, active high
  input  wire logic [2:0]   i_link_no,          // link number minus one
  input  wire logic [3:0]   i_station,          // failing station 1..15
  input  wire logic [14:0]  i_separated,        // bit n-1: station n separated
  input  wire logic         i_hpar_err,         // master: horizontal parity mismatch
  input  wire logic         i_hpar_missing,     // master: no horizontal parity data
  input  wire logic         i_vpar_err,         // master: vertical parity error
  input  wire logic         i_no_master_data,   // slave: no normal data from master
  input  wire logic         i_hw_fault,         // module or interface fault
  input  wire logic         i_param_bad,        // inconsistent link parameter
  input  wire logic [2:0]   i_rd_idx,           // history index, 0 newest
  output logic              o_log_stb,          // one cycle per stored record
  output logic [7:0]        o_last_class,       // class of newest record
  output logic [3:0]        o_last_link_code,   // link code of newest record
  output logic [15:0]       o_last_word0,       // newest first word
  output logic [15:0]       o_last_detail,      // newest detail word
  output logic [15:0]       o_last_station,     // newest station word
  output logic [14:0]       o_station_off,      // communication data held off
  output logic [3:0]        o_hist_count,       // entries in history
  output logic [7:0]        o_rd_class,         // read port: class
  output logic [3:0]        o_rd_link_code,     // read port: link code
  output logic [15:0]       o_rd_word0,         // read port: first word
  output logic [15:0]       o_rd_detail,        // read port: detail word
  output logic [15:0]       o_rd_station        // read port: station word
);
  err_rec_if hist ();  // carrier to the history store

  // station decode
  logic        station_ok;     // station number in 1..15
  logic        station_sep;    // failing station is separated
  logic        station_live;   // station errors may be logged
  logic [7:0]  station_addr;   // reported station address
  logic [3:0]  link_code;      // odd digit for the link
  logic [15:0] word0_normal;   // 10, station, 4
  logic [15:0] station_word;   // address in the low byte

  assign station_ok   = i_station != 4'h0;
  assign station_sep  = station_ok && i_separated[3'(0) + 4'(i_station - 4'h1)];
  assign station_live = station_ok && !station_sep;
  assign station_addr = 8'(link_err_pkg::STATION_ADDR_FIRST + {4'h0, i_station} - 8'h01);
  assign link_code    = {i_link_no, 1'b1};
  assign word0_normal = {link_err_pkg::WORD0_SEQ_HIGH, i_station,
                         link_err_pkg::WORD0_NORMAL_SEQ};
  assign station_word = {8'h00, station_addr};

  // event qualification, highest priority first
  logic take_hw;       // hardware fault
  logic take_param;    // parameter fault
  logic take_vpar;     // vertical parity
  logic take_hpar;     // horizontal parity mismatch
  logic take_hmiss;    // horizontal parity missing
  logic take_nomst;    // slave saw no master data
  logic log_now;       // a record is formed this cycle

  assign take_hw    = i_hw_fault;
  assign take_param = !take_hw && i_param_bad;
  assign take_vpar  = !take_hw && !take_param && i_vpar_err && station_live;
  assign take_hpar  = !take_hw && !take_param && !i_vpar_err && i_hpar_err
                      && station_live;
  assign take_hmiss = !take_hw && !take_param && !i_vpar_err && !i_hpar_err
                      && i_hpar_missing && station_live;
  assign take_nomst = !take_hw && !take_param && !take_vpar && !take_hpar
                      && !take_hmiss && i_no_master_data;
  assign log_now    = take_hw | take_param | take_vpar | take_hpar | take_hmiss | take_nomst;

  // record assembly
  link_err_pkg::record_t next_rec;  // record for this cycle's event
  logic                  seq_err;   // any station sequence error

  assign seq_err = take_vpar | take_hpar | take_hmiss;

  assign next_rec.link_code  = link_code;
  assign next_rec.class_code =
      take_hw    ? link_err_pkg::CLASS_HW_FAULT :
      take_param ? link_err_pkg::CLASS_PARAM_BAD :
                   link_err_pkg::CLASS_LINK_SEQ;
  assign next_rec.error_record_word0 =
      seq_err    ? word0_normal :
      take_nomst ? link_err_pkg::WORD0_NO_MASTER :
                   link_err_pkg::WORD_NONE;
  assign next_rec.error_detail_word =
      take_vpar  ? link_err_pkg::DETAIL_VPAR_ERR :
      take_hpar  ? link_err_pkg::DETAIL_HPAR_ERR :
      take_hmiss ? link_err_pkg::DETAIL_HPAR_MISSING :
      take_nomst ? link_err_pkg::DETAIL_NO_MASTER :
                   link_err_pkg::WORD_NONE;
  assign next_rec.error_station_word = seq_err ? station_word : link_err_pkg::WORD_NONE;

  // hand the record to the history
  assign hist.push   = log_now;
  assign hist.rec    = next_rec;
  assign hist.rd_idx = i_rd_idx;

  err_history #(
    .DEPTH (link_err_pkg::HIST_DEPTH)
  ) u_history (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .hist       (hist.store)
  );

  // newest-record outputs
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      o_log_stb        <= 1'b0;
      o_last_class     <= 8'h00;
      o_last_link_code <= 4'h0;
      o_last_word0     <= 16'h0000;
      o_last_detail    <= 16'h0000;
      o_last_station   <= 16'h0000;
    end
    else
    begin
      o_log_stb <= log_now;
      // hold the previous record when nothing is logged
      if (log_now)
      begin
        o_last_class     <= next_rec.class_code;
        o_last_link_code <= next_rec.link_code;
        o_last_word0     <= next_rec.error_record_word0;
        o_last_detail    <= next_rec.error_detail_word;
        o_last_station   <= next_rec.error_station_word;
      end
    end
  end

  // separated stations keep their data off
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      o_station_off <= 15'h0000;
    else
      o_station_off <= i_separated;
  end

  // history flops are passed straight out
  assign o_hist_count   = hist.count;
  assign o_rd_class     = hist.rd_rec.class_code;
  assign o_rd_link_code = hist.rd_rec.link_code;
  assign o_rd_word0     = hist.rd_rec.error_record_word0;
  assign o_rd_detail    = hist.rd_rec.error_detail_word;
  assign o_rd_station   = hist.rd_rec.error_station_word;

  // checks
  link_code_map_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    log_now |=> o_log_stb && o_last_link_code == {$past(i_link_no), 1'b1}
                && o_last_link_code[0])
    else $error("link code is not the odd digit of the link");

  station_addr_map_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    seq_err |=> o_last_station[7:0] == 8'(8'h61 + {4'h0, $past(i_station)})
                && o_last_station[15:8] == 8'h00)
    else $error("station address does not follow the station number");

  hpar_record_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_hpar_err && station_live && !i_hw_fault && !i_param_bad && !i_vpar_err
    |=> o_log_stb && o_last_class == 8'h86
        && o_last_word0 == {8'h10, $past(i_station), 4'h4} && o_last_detail == 16'h0000)
    else $error("horizontal parity record malformed");

  hpar_missing_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    take_hmiss |=> o_last_class == 8'h86 && o_last_detail == 16'h00E6
                   && o_last_station[7:0] == $past(station_addr))
    else $error("missing parity record malformed");

  no_master_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_no_master_data && !i_hw_fault && !i_param_bad && !seq_err
    |=> o_log_stb && o_last_class == 8'h86 && o_last_word0 == 16'h1007
        && o_last_detail == 16'h00E4)
    else $error("no-master-data record malformed");

  hw_fault_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_hw_fault |=> o_log_stb && o_last_class == 8'h84)
    else $error("hardware fault not logged as 84");

  param_bad_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_param_bad && !i_hw_fault |=> o_log_stb && o_last_class == 8'h89)
    else $error("parameter fault not logged as 89");

  hist_fill_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    o_log_stb |-> o_hist_count == (($past(o_hist_count) == 4'h8) ? 4'h8
                                   : 4'($past(o_hist_count) + 4'h1)))
    else $error("history count did not advance with a record");

  sep_quiet_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    station_sep && !i_hw_fault && !i_param_bad && !i_no_master_data
    |=> !o_log_stb && $stable(o_hist_count))
    else $error("separated station produced an error record");

  vpar_record_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    take_vpar |=> o_last_class == 8'h86 && o_last_detail == 16'h00E8
                  && o_last_word0[3:0] == 4'h4)
    else $error("vertical parity record malformed");

  // off mask follows the separated stations one cycle later
  station_off_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    1'b1 |=> o_station_off == $past(i_separated))
    else $error("separated stations not held off");

  // no event: no strobe, history and newest record untouched
  idle_hold_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    !log_now |=> !o_log_stb && $stable(o_hist_count) && $stable(o_last_word0)
                 && $stable(o_last_class))
    else $error("history or newest record changed without an event");

  // fill level never passes the history depth
  hist_bound_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    o_hist_count <= 4'h8)
    else $error("history holds more than eight entries");
endmodule
`default_nettype wire

// >>> testbench/station_model.sv
`default_nettype none
// remote station side: raises one parity condition for the named station
module station_model (
  input  wire logic       i_go,           // one event this cycle
  input  wire logic [2:0] i_kind,         // 0 mismatch, 1 missing, 2 vertical
  input  wire logic [3:0] i_st,           // reporting station
  output logic [3:0]      o_station,      // station seen by the master
  output logic            o_hpar_err,     // horizontal parity mismatch
  output logic            o_hpar_missing, // horizontal parity absent
  output logic            o_vpar_err      // vertical parity error
);
  timeunit 1ns;
  timeprecision 1ns;
  // flags only while a request is present, never left standing
  assign o_station      = i_st;
  assign o_hpar_err     = i_go && (i_kind == 3'h0);
  assign o_hpar_missing = i_go && (i_kind == 3'h1);
  assign o_vpar_err     = i_go && (i_kind == 3'h2);
endmodule
`default_nettype wire

// >>> testbench/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_core_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic [2:0]  i_link_no = 3'h0;
  logic [14:0] i_separated = 15'h0000;
  logic        i_no_master_data = 1'b0;
  logic        i_hw_fault = 1'b0;
  logic        i_param_bad = 1'b0;
  logic [2:0]  i_rd_idx = 3'h0;
  logic        go = 1'b0;      // partner request
  logic [2:0]  kind = 3'h0;    // partner event kind
  logic [3:0]  st = 4'h1;      // partner station
  wire logic [3:0] i_station;
  wire logic i_hpar_err, i_hpar_missing, i_vpar_err, o_log_stb;
  wire logic [7:0] o_last_class, o_rd_class;
  wire logic [3:0] o_last_link_code, o_rd_link_code, o_hist_count;
  wire logic [15:0] o_last_word0, o_last_detail, o_last_station;
  wire logic [15:0] o_rd_word0, o_rd_detail, o_rd_station;
  wire logic [14:0] o_station_off;
  int err_count = 0;
  int checked = 0;
  // free-running system clock
  always #5 i_core_clk = ~i_core_clk;
  station_model partner (.i_go(go), .i_kind(kind), .i_st(st), .o_station(i_station),
    .o_hpar_err(i_hpar_err), .o_hpar_missing(i_hpar_missing), .o_vpar_err(i_vpar_err));
  link_error_code_logger dut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
    .i_link_no(i_link_no), .i_station(i_station), .i_separated(i_separated),
    .i_hpar_err(i_hpar_err), .i_hpar_missing(i_hpar_missing), .i_vpar_err(i_vpar_err),
    .i_no_master_data(i_no_master_data), .i_hw_fault(i_hw_fault),
    .i_param_bad(i_param_bad), .i_rd_idx(i_rd_idx), .o_log_stb(o_log_stb),
    .o_last_class(o_last_class), .o_last_link_code(o_last_link_code),
    .o_last_word0(o_last_word0), .o_last_detail(o_last_detail),
    .o_last_station(o_last_station), .o_station_off(o_station_off),
    .o_hist_count(o_hist_count), .o_rd_class(o_rd_class),
    .o_rd_link_code(o_rd_link_code), .o_rd_word0(o_rd_word0),
    .o_rd_detail(o_rd_detail), .o_rd_station(o_rd_station));
  // verdict and end of run
  task automatic print_verdict;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // one compare, four-state exact
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // present one event for one cycle; caller lowers it with idle
  task automatic ev(input logic [2:0] k, input logic [3:0] s, input logic [2:0] l);
    kind = k;
    st = s;
    i_link_no = l;
    go = (k < 3'h3);
    i_no_master_data = (k == 3'h3);
    i_hw_fault = (k == 3'h4);
    i_param_bad = (k == 3'h5);
    @(negedge i_core_clk);
  endtask
  // drop all event lines for one cycle
  task automatic idle;
    go = 1'b0;
    i_no_master_data = 1'b0;
    i_hw_fault = 1'b0;
    i_param_bad = 1'b0;
    @(negedge i_core_clk);
  endtask
  // newest record against the expected fields of one event
  task automatic chk_last(input logic [2:0] k, input logic [3:0] s, input logic [2:0] l);
    logic [15:0] cl, w0, dt, sw;
    cl = (k == 3'h4) ? 16'h0084 : (k == 3'h5) ? 16'h0089 : 16'h0086;
    w0 = (k < 3'h3) ? {8'h10, s, 4'h4} : (k == 3'h3) ? 16'h1007 : 16'h0000;
    dt = (k == 3'h1) ? 16'h00e6 : (k == 3'h2) ? 16'h00e8 : (k == 3'h3) ? 16'h00e4 : 16'h0000;
    sw = (k < 3'h3) ? 16'h0062 + {12'h000, s} - 16'h0001 : 16'h0000;
    chk({15'h0000, o_log_stb}, 16'h0001);
    chk({8'h00, o_last_class}, cl);
    chk({12'h000, o_last_link_code}, {12'h000, l, 1'b1});
    chk(o_last_word0, w0);
    chk(o_last_detail, dt);
    chk(o_last_station, sw);
  endtask
  // outputs while reset is held
  task automatic t_reset;
    chk({12'h000, o_hist_count}, 16'h0000);
    chk({15'h0000, o_log_stb}, 16'h0000);
    chk({8'h00, o_last_class}, 16'h0000);
    chk(o_rd_station, 16'h0000);
  endtask
  // separated station and station 0 are refused, slave fault still logged
  task automatic t_separated;
    i_separated = 15'h0004;
    ev(3'h0, 4'h3, 3'h0);
    chk({15'h0000, o_log_stb}, 16'h0000);
    chk({12'h000, o_hist_count}, 16'h0000);
    chk({1'b0, o_station_off}, 16'h0004);
    idle;
    ev(3'h1, 4'h0, 3'h0);
    chk({15'h0000, o_log_stb}, 16'h0000);
    ev(3'h3, 4'h3, 3'h1);
    chk_last(3'h3, 4'h3, 3'h1);
    i_separated = 15'h0000;
    idle;
  endtask
  // nine back-to-back records, read history newest first
  task automatic t_history;
    for (int i = 1; i <= 9; i++)
      ev(3'h0, 4'(i), 3'h0);
    idle;
    chk({12'h000, o_hist_count}, 16'h0008);
    for (int j = 0; j < 8; j++)
    begin
      i_rd_idx = 3'(j);
      @(negedge i_core_clk);
      chk(o_rd_station, 16'h0061 + 16'(9 - j));
      chk(o_rd_word0, {8'h10, 4'(9 - j), 4'h4});
      chk({8'h00, o_rd_class}, 16'h0086);
      chk({12'h000, o_rd_link_code}, 16'h0001);
      chk(o_rd_detail, 16'h0000);
    end
  endtask
  // every station, every station fault kind, links spread across 1..8
  task automatic t_sweep;
    for (int s = 1; s <= 15; s++)
      for (int k = 0; k < 3; k++)
      begin
        ev(3'(k), 4'(s), 3'(s + k));
        chk_last(3'(k), 4'(s), 3'(s + k));
        idle;
      end
    chk({12'h000, o_hist_count}, 16'h0008);
  endtask
  // slave, hardware and parameter faults back to back
  task automatic t_alarms;
    ev(3'h3, 4'h1, 3'h7);
    chk_last(3'h3, 4'h1, 3'h7);
    ev(3'h4, 4'h1, 3'h6);
    chk_last(3'h4, 4'h1, 3'h6);
    ev(3'h5, 4'h1, 3'h5);
    chk_last(3'h5, 4'h1, 3'h5);
    // hardware fault beats parameter and vertical parity in one cycle
    i_hw_fault = 1'b1;
    kind = 3'h2;
    go = 1'b1;
    @(negedge i_core_clk);
    chk_last(3'h4, 4'h1, 3'h5);
    idle;
    chk({15'h0000, o_log_stb}, 16'h0000);
  endtask
  // reset in mid-run empties the history, then logging resumes
  task automatic t_rerst;
    i_sys_rst = 1'b1;
    @(negedge i_core_clk);
    i_sys_rst = 1'b0;
    chk({12'h000, o_hist_count}, 16'h0000);
    chk({15'h0000, o_log_stb}, 16'h0000);
    chk({8'h00, o_last_class}, 16'h0000);
    chk(o_rd_station, 16'h0000);
    @(negedge i_core_clk);
    ev(3'h4, 4'h1, 3'h2);
    chk_last(3'h4, 4'h1, 3'h2);
    idle;
    chk({12'h000, o_hist_count}, 16'h0001);
  endtask
  // watchdog against a hung run
  initial
  begin
    #20000;
    err_count++;
    print_verdict;
  end
  // main sequence
  initial
  begin
    repeat (3) @(negedge i_core_clk);
    t_reset;
    i_sys_rst = 1'b0;
    @(negedge i_core_clk);
    t_separated;
    t_history;
    t_sweep;
    t_alarms;
    t_rerst;
    print_verdict;
  end
endmodule
`default_nettype wire
